/* File: hdl/ncfg_regs.sv */
// Register group for the fine-mixer NCO frequency word and the clock-multiplier PLL.
//
// ---------------------------------------------------------------------------
// What this block does
// - Frequency word is signed, Fs/2^32 per step.
// - Word low half at 0x14, high at 0x15.
// - Loop filter reset bit discharges filter.
// - Bit 11 lets sync input align dividers.
// - Bit 10 selects PLL clock or bypass.
// - Bits 7:6 choose charge pump configuration.
// - Prescaler codes 1..7, zero means 8.
// - Bits 2:0 read filter voltage, write-ignored.
// - M bit7 zero: ratio is low seven.
// - M bit7 one: ratio twice low seven.
// - N ratio is code plus one.
// - Frequency takes effect only on sync load.
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
module ncfg_regs (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [6:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [15:0]          reg_rdata,
    // Mixer load control
    input  wire logic                 mixer_sync_load,
    input  wire logic                 sample_en,
    output logic      [31:0]          active_freq_word,
    output logic      [31:0]          phase_acc,
    // PLL analog controls
    input  wire logic [2:0]           loop_filter_volt,
    input  wire logic                 lvds_sync,
    output logic                      loop_filter_discharge,
    output logic                      pll_clock_select,
    output logic                      ndiv_sync_pulse,
    output logic      [1:0]           charge_pump_select,
    output logic                      charge_pump_dual,
    output logic      [3:0]           prescale_ratio,
    output logic      [7:0]           m_ratio,
    output logic                      m_ratio_valid,
    output logic      [4:0]           n_ratio,
    output logic      [1:0]           vco_bias_tune
);
    import ncfg_pkg::*;

    // -----------------------------------------------------------------------
    // Decoding helpers
    // -----------------------------------------------------------------------
    function automatic logic [3:0] ncfg_pre_ratio(input logic [2:0] code);
        ncfg_pre_ratio = (code == 3'h0) ? 4'h8 : {1'b0, code};
    endfunction : ncfg_pre_ratio

    function automatic logic [7:0] ncfg_m_ratio(input logic [7:0] code);
        ncfg_m_ratio = code[7] ? {code[6:0], 1'b0} : {1'b0, code[6:0]};
    endfunction : ncfg_m_ratio

    function automatic logic ncfg_m_valid(input logic [7:0] code);
        ncfg_m_valid = code[7] ? (code[6:0] >= 7'h04) : (code[6:0] >= 7'h04);
    endfunction : ncfg_m_valid

    // -----------------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------------
    logic [15:0] freq_low;
    logic [15:0] freq_high;
    logic [15:0] pll_ctrl;
    logic [15:0] pll_div;
    logic [2:0]  lf_volt_sync;
    logic        sync_lvds;
    logic        sync_prev;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            freq_low  <= RST_FREQ_LOW;
            freq_high <= RST_FREQ_HIGH;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_FREQ_LOW) begin
                freq_low <= reg_wdata;
            end
            if (reg_addr == ADDR_FREQ_HIGH) begin
                freq_high <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pll_ctrl <= RST_PLL_CTRL;
        end else if (reg_wr && reg_addr == ADDR_PLL_CTRL) begin
            pll_ctrl <= reg_wdata & CTRL_WR_MASK;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pll_div <= RST_PLL_DIV;
        end else if (reg_wr && reg_addr == ADDR_PLL_DIV) begin
            pll_div <= reg_wdata;
        end
    end

    // -----------------------------------------------------------------------
    // Mixer load and accumulator
    // -----------------------------------------------------------------------
    // Holding the active word apart keeps a half-written 32-bit step off the mixer.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            active_freq_word <= {RST_FREQ_HIGH, RST_FREQ_LOW};
        end else if (mixer_sync_load) begin
            active_freq_word <= {freq_high, freq_low};
        end
    end

    // Signed and unsigned addition agree modulo 2^32, so the sign needs no extra logic.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_acc <= 32'h00000000;
        end else if (sample_en) begin
            phase_acc <= phase_acc + active_freq_word;
        end
    end

    // -----------------------------------------------------------------------
    // PLL controls
    // -----------------------------------------------------------------------
    assign loop_filter_discharge = pll_ctrl[CTRL_LF_RESET];
    assign pll_clock_select      = pll_ctrl[CTRL_PLL_ENA];
    assign charge_pump_select    = pll_ctrl[CTRL_CP_LSB +: 2];
    assign charge_pump_dual      = (charge_pump_select == CP_DUAL);
    assign prescale_ratio        = ncfg_pre_ratio(pll_ctrl[CTRL_PRE_LSB +: 3]);
    assign m_ratio               = ncfg_m_ratio(pll_div[DIV_M_LSB +: 8]);
    assign m_ratio_valid         = ncfg_m_valid(pll_div[DIV_M_LSB +: 8]);
    assign n_ratio               = {1'b0, pll_div[DIV_N_LSB +: 4]} + 5'h01;
    assign vco_bias_tune         = pll_div[DIV_BIAS_LSB +: 2];

    // The sync pin has a synchroniser of its own, so its edge never waits on the voltage code.
    ncfg_sync3 #(
        .W (1)
    ) u_sync_in (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (lvds_sync),
        .dout    (sync_lvds)
    );

    ncfg_sync3 #(
        .W (3)
    ) u_sync_volt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (loop_filter_volt),
        .dout    (lf_volt_sync)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= sync_lvds;
        end
    end

    // A level held high on the sync pin gives one pulse; only a fresh rising edge aligns again.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ndiv_sync_pulse <= 1'b0;
        end else begin
            ndiv_sync_pulse <= pll_ctrl[CTRL_NSYNC_ENA] && sync_lvds && !sync_prev;
        end
    end

    // -----------------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_FREQ_LOW:  reg_rdata <= freq_low;
                ADDR_FREQ_HIGH: reg_rdata <= freq_high;
                ADDR_RSVD_A:    reg_rdata <= RST_RSVD;
                ADDR_RSVD_B:    reg_rdata <= RST_RSVD;
                ADDR_PLL_CTRL:  reg_rdata <= {pll_ctrl[15:3], lf_volt_sync};
                ADDR_PLL_DIV:   reg_rdata <= pll_div;
                default:        reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    a_freq_hold_write: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_FREQ_LOW && !mixer_sync_load)
        |=> $stable(active_freq_word))
        else $error("frequency write changed active word");
    a_freq_load_join: assert property (@(posedge sys_clk) disable iff (rst)
        mixer_sync_load |=> active_freq_word == {$past(freq_high), $past(freq_low)})
        else $error("active word not loaded from both halves");
    a_acc_step: assert property (@(posedge sys_clk) disable iff (rst)
        sample_en |=> phase_acc == $past(phase_acc) + $past(active_freq_word))
        else $error("accumulator step wrong");
    a_acc_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !sample_en |=> $stable(phase_acc))
        else $error("accumulator moved without sample");
    a_lf_discharge: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_PLL_CTRL) |=>
        loop_filter_discharge == $past(reg_wdata[CTRL_LF_RESET]))
        else $error("loop filter reset not following write");
    a_pll_select: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_PLL_CTRL) |=>
        pll_clock_select == $past(reg_wdata[CTRL_PLL_ENA]))
        else $error("pll select not following write");
    a_volt_readonly: assert property (@(posedge sys_clk) disable iff (rst)
        pll_ctrl[2:0] == 3'h0)
        else $error("read-only voltage bits stored");
    a_ctrl_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_PLL_CTRL) |=> reg_rdata[2:0] == $past(lf_volt_sync))
        else $error("voltage code not on read");
    a_pre_ratio: assert property (@(posedge sys_clk) disable iff (rst)
        (pll_ctrl[CTRL_PRE_LSB +: 3] == 3'h0) |-> prescale_ratio == 4'h8)
        else $error("prescaler zero code not eight");
    a_m_ratio: assert property (@(posedge sys_clk) disable iff (rst)
        pll_div[15] |-> m_ratio == {pll_div[14:8], 1'b0})
        else $error("doubled m ratio wrong");
    a_m_direct: assert property (@(posedge sys_clk) disable iff (rst)
        !pll_div[15] |-> (m_ratio == {1'b0, pll_div[14:8]}
        && m_ratio_valid == (pll_div[14:8] >= 7'h04)))
        else $error("direct m ratio wrong");
    a_n_ratio: assert property (@(posedge sys_clk) disable iff (rst)
        n_ratio == {1'b0, pll_div[7:4]} + 5'h01)
        else $error("n ratio not code plus one");
    a_cp_dual: assert property (@(posedge sys_clk) disable iff (rst)
        charge_pump_dual |-> pll_ctrl[7:6] == CP_DUAL)
        else $error("dual pump without code");
    a_nsync_gate: assert property (@(posedge sys_clk) disable iff (rst)
        ndiv_sync_pulse |-> $past(pll_ctrl[CTRL_NSYNC_ENA]))
        else $error("divider sync while disabled");
    a_freq_high_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_FREQ_HIGH && !mixer_sync_load)
        |=> $stable(active_freq_word))
        else $error("high word write changed active word");
    a_freq_low_store: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_FREQ_LOW) |=> freq_low == $past(reg_wdata))
        else $error("low word not stored");
    a_freq_high_store: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_FREQ_HIGH) |=> freq_high == $past(reg_wdata))
        else $error("high word not stored");
    a_cp_follow: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_PLL_CTRL) |=>
        charge_pump_select == $past(reg_wdata[CTRL_CP_LSB +: 2]))
        else $error("charge pump select not following write");
    a_pre_direct: assert property (@(posedge sys_clk) disable iff (rst)
        (pll_ctrl[CTRL_PRE_LSB +: 3] != 3'h0) |-> prescale_ratio == {1'b0, pll_ctrl[5:3]})
        else $error("prescaler code not used directly");
    a_m_valid_dbl: assert property (@(posedge sys_clk) disable iff (rst)
        pll_div[15] |-> m_ratio_valid == (pll_div[14:8] >= 7'h04))
        else $error("doubled m validity wrong");
    a_nsync_single: assert property (@(posedge sys_clk) disable iff (rst)
        ndiv_sync_pulse |=> !ndiv_sync_pulse)
        else $error("divider sync pulse longer than one cycle");
    a_nsync_edge: assert property (@(posedge sys_clk) disable iff (rst)
        ndiv_sync_pulse |-> ($past(sync_lvds) && !$past(sync_lvds, 2)))
        else $error("divider sync without rising edge");
    a_dischg_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !(reg_wr && reg_addr == ADDR_PLL_CTRL) |=>
        $stable(loop_filter_discharge))
        else $error("loop filter reset moved without write");
    a_clk_sel_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !(reg_wr && reg_addr == ADDR_PLL_CTRL) |=>
        $stable(pll_clock_select))
        else $error("pll select moved without write");
    a_ctrl_upper_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_PLL_CTRL) |=>
        reg_rdata[15:3] == $past(pll_ctrl[15:3]))
        else $error("control fields not on read");
    a_ctrl_mask_write: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_PLL_CTRL) |=>
        pll_ctrl[15:3] == $past(reg_wdata[15:3]))
        else $error("writable control fields not stored");
    a_freq_low_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_FREQ_LOW) |=> reg_rdata == $past(freq_low))
        else $error("low word not on read");
    a_freq_high_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_FREQ_HIGH) |=> reg_rdata == $past(freq_high))
        else $error("high word not on read");
    a_cp_dual_code: assert property (@(posedge sys_clk) disable iff (rst)
        (charge_pump_select == CP_DUAL) |-> charge_pump_dual)
        else $error("dual code without dual pump");
    a_n_ratio_range: assert property (@(posedge sys_clk) disable iff (rst)
        (n_ratio >= 5'h01) && (n_ratio <= 5'h10))
        else $error("n ratio out of range");
endmodule : ncfg_regs

/* File: hdl/ncfg_pkg.sv */
// Package with offsets, field positions, reset values and encodings of the NCO and PLL registers.
package ncfg_pkg;

    localparam logic [6:0]  ADDR_FREQ_LOW   = 7'h14;
    localparam logic [6:0]  ADDR_FREQ_HIGH  = 7'h15;
    localparam logic [6:0]  ADDR_RSVD_A     = 7'h16;
    localparam logic [6:0]  ADDR_RSVD_B     = 7'h17;
    localparam logic [6:0]  ADDR_PLL_CTRL   = 7'h18;
    localparam logic [6:0]  ADDR_PLL_DIV    = 7'h19;

    localparam logic [15:0] RST_FREQ_LOW    = 16'h0000;
    localparam logic [15:0] RST_FREQ_HIGH   = 16'h0000;
    localparam logic [15:0] RST_RSVD        = 16'h0000;
    // Control register: reserved 15:13 = 001, sync enable set, prescaler 001.
    localparam logic [15:0] RST_PLL_CTRL    = 16'h2808;
    localparam logic [15:0] RST_PLL_DIV     = 16'h0440;

    localparam int          CTRL_LF_RESET   = 12;
    localparam int          CTRL_NSYNC_ENA  = 11;
    localparam int          CTRL_PLL_ENA    = 10;
    localparam int          CTRL_CP_LSB     = 6;
    localparam int          CTRL_PRE_LSB    = 3;
    localparam logic [15:0] CTRL_WR_MASK    = 16'hfff8;

    localparam int          DIV_M_LSB       = 8;
    localparam int          DIV_N_LSB       = 4;
    localparam int          DIV_BIAS_LSB    = 2;

    localparam logic [1:0]  CP_NONE         = 2'h0;
    localparam logic [1:0]  CP_SINGLE       = 2'h1;
    localparam logic [1:0]  CP_UNUSED       = 2'h2;
    localparam logic [1:0]  CP_DUAL         = 2'h3;

    typedef enum logic [2:0] {
        NCFG_IDLE  = 3'b001,
        NCFG_ARMED = 3'b010,
        NCFG_LOAD  = 3'b100
    } ncfg_sync_t;

endpackage : ncfg_pkg

/* File: hdl/ncfg_sync3.sv */
// Three-flop synchroniser that reports a change once stages two and three agree.
`timescale 1ns/10ps
module ncfg_sync3 #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Holding the old value until two stages agree filters a code caught mid-change.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dout <= '0;
        end else if (s2 == s3) begin
            dout <= s3;
        end
    end
endmodule : ncfg_sync3

/* File: testbench/testbench.sv */
// Self-checking bench for the NCO frequency and PLL configuration register group.
`timescale 1ns/10ps
module testbench;
    import ncfg_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        sys_clk          = 1'b0;
    logic        rst              = 1'b1;
    logic [6:0]  reg_addr         = 7'h00;
    logic [15:0] reg_wdata        = 16'h0000;
    logic        reg_wr           = 1'b0;
    logic        reg_rd           = 1'b0;
    logic        mixer_sync_load  = 1'b0;
    logic        sample_en        = 1'b0;
    logic [2:0]  loop_filter_volt = 3'h5;
    logic        lvds_sync        = 1'b0;
    logic [15:0] reg_rdata;
    logic [31:0] active_freq_word;
    logic [31:0] phase_acc;
    logic        loop_filter_discharge;
    logic        pll_clock_select;
    logic        ndiv_sync_pulse;
    logic        charge_pump_dual;
    logic        m_ratio_valid;
    logic [1:0]  charge_pump_select;
    logic [1:0]  vco_bias_tune;
    logic [3:0]  prescale_ratio;
    logic [7:0]  m_ratio;
    logic [4:0]  n_ratio;
    // Model state: register images, active word and accumulator.
    logic [15:0] flo  = RST_FREQ_LOW;
    logic [15:0] fhi  = RST_FREQ_HIGH;
    logic [15:0] ctrl = RST_PLL_CTRL;
    logic [15:0] div  = RST_PLL_DIV;
    logic [15:0] d;
    logic [31:0] aw   = 32'h0000_0000;
    logic [31:0] acc  = 32'h0000_0000;
    integer      fails = 0, checked = 0, cycles = 0, pulses = 0, p0 = 0, seed = 32'h2d2e;
    // M codes around both validity boundaries in both modes.
    logic [7:0]  mtab [0:7] = '{8'h00, 8'h03, 8'h04, 8'h7f, 8'h80, 8'h83, 8'h84, 8'hff};

    ncfg_regs i_ncfg_regs (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .mixer_sync_load, .sample_en, .active_freq_word, .phase_acc, .loop_filter_volt,
        .lvds_sync, .loop_filter_discharge, .pll_clock_select, .ndiv_sync_pulse,
        .charge_pump_select, .charge_pump_dual, .prescale_ratio, .m_ratio, .m_ratio_valid,
        .n_ratio, .vco_bias_tune);

    always #2.5 sys_clk = ~sys_clk;

    // The run needs well under a thousand cycles; the ceiling only catches a hang.
    always @(posedge sys_clk) begin
        cycles++;
        if (ndiv_sync_pulse === 1'b1) pulses++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Model and checks
    // ------------------------------------------------------------------
    task automatic conclude();
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Voltage code is read live; callers wait out the synchroniser first.
    function automatic logic [15:0] mread(input logic [6:0] a);
        case (a)
            ADDR_FREQ_LOW:  return flo;
            ADDR_FREQ_HIGH: return fhi;
            ADDR_PLL_CTRL:  return {ctrl[15:3], loop_filter_volt};
            ADDR_PLL_DIV:   return div;
            default:        return 16'h0000;
        endcase
    endfunction : mread

    task automatic chk_dec();
        #1;
        chk(loop_filter_discharge, ctrl[CTRL_LF_RESET]);
        chk(pll_clock_select, ctrl[CTRL_PLL_ENA]);
        chk(charge_pump_select, ctrl[7:6]);
        chk(charge_pump_dual, ctrl[7:6] == CP_DUAL);
        chk(prescale_ratio, (ctrl[5:3] == 3'h0) ? 4'h8 : {1'b0, ctrl[5:3]});
        chk(m_ratio, div[15] ? {div[14:8], 1'b0} : {1'b0, div[14:8]});
        chk(m_ratio_valid, div[14:8] >= 7'h04);
        chk(n_ratio, div[7:4] + 5'h01);
        chk(vco_bias_tune, div[3:2]);
    endtask : chk_dec

    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        case (a)
            ADDR_FREQ_LOW:  flo = v;
            ADDR_FREQ_HIGH: fhi = v;
            ADDR_PLL_CTRL:  ctrl = v & CTRL_WR_MASK;
            ADDR_PLL_DIV:   div = v;
            default:        ;
        endcase
        chk_dec();
    endtask : wr

    task automatic rd(input logic [6:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, mread(a));
    endtask : rd

    task automatic load();
        @(posedge sys_clk);
        mixer_sync_load <= 1'b1;
        @(posedge sys_clk);
        mixer_sync_load <= 1'b0;
        aw = {fhi, flo};
        #1 chk(active_freq_word, aw);
    endtask : load

    task automatic step(input int k);
        @(posedge sys_clk);
        sample_en <= 1'b1;
        repeat (k) @(posedge sys_clk);
        sample_en <= 1'b0;
        acc = acc + k * aw;
        #1 chk(phase_acc, acc);
    endtask : step

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk_dec();
        chk(active_freq_word, aw);
        chk(phase_acc, acc);
        for (int a = 'h12; a <= 'h1a; a++) rd(a[6:0]);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[5:3] = i[2:0];
            d[7:6] = i[1:0];
            wr(ADDR_PLL_CTRL, d);
            rd(ADDR_PLL_CTRL);
        end
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            d[7:4] = i[3:0];
            d[15:8] = mtab[i[2:0]];
            wr(ADDR_PLL_DIV, d);
            rd(ADDR_PLL_DIV);
        end
        wr(ADDR_RSVD_A, 16'hffff);
        wr(ADDR_RSVD_B, 16'ha5a5);
        wr(7'h7f, 16'hffff);
        rd(ADDR_RSVD_A);
        rd(ADDR_RSVD_B);
        rd(7'h7f);
        // The second pass uses a negative word so the accumulator must count down.
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            wr(ADDR_FREQ_LOW, (k == 1) ? 16'hfff0 : d);
            wr(ADDR_FREQ_HIGH, (k == 1) ? 16'hffff : d ^ 16'h5a5a);
            chk(active_freq_word, aw);
            step(3);
            load();
            step(7 + k);
        end
        @(posedge sys_clk);
        loop_filter_volt <= 3'h2;
        repeat (6) @(posedge sys_clk);
        rd(ADDR_PLL_CTRL);
        wr(ADDR_PLL_CTRL, 16'h3c08);
        wr(ADDR_PLL_CTRL, 16'h2808);
        p0 = pulses;
        @(posedge sys_clk);
        lvds_sync <= 1'b1;
        repeat (10) @(posedge sys_clk);
        lvds_sync <= 1'b0;
        chk(pulses - p0, 1);
        repeat (10) @(posedge sys_clk);
        wr(ADDR_PLL_CTRL, 16'h2008);
        p0 = pulses;
        @(posedge sys_clk);
        lvds_sync <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk(pulses - p0, 0);
        conclude();
    end
endmodule : testbench
